// ### hdl/tpm_core_pkg.sv
// constants and types for the timer counter and channel value core
package tpm_core_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_TIMER_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_MAIN_COUNTER_HIGH = 8'h01;
   localparam logic [7:0] OFS_MAIN_COUNTER_LOW = 8'h02;
   localparam logic [7:0] OFS_MODULUS_HIGH = 8'h03;
   localparam logic [7:0] OFS_MODULUS_LOW = 8'h04;
   localparam logic [7:0] OFS_CHANNEL_STATUS_CONTROL = 8'h05;
   localparam logic [7:0] OFS_CHANNEL_VALUE_HIGH = 8'h06;
   localparam logic [7:0] OFS_CHANNEL_VALUE_LOW = 8'h07;
   // timer status control fields
   localparam int TSC_OVERFLOW_FLAG_BIT = 7;
   localparam int TSC_OVERFLOW_IE_BIT = 6;
   localparam int TSC_CENTER_SEL_BIT = 5;
   localparam int TSC_CLOCK_SEL_LSB = 3;
   // channel status control fields
   localparam int CSC_MODE_UPPER_BIT = 5;
   localparam int CSC_MODE_LOWER_BIT = 4;
   localparam int CSC_EDGE_LSB = 2;
   localparam logic [7:0] CSC_WRITE_MASK = 8'h3C;
   localparam logic [7:0] TSC_WRITE_MASK = 8'h78;
   // reset values
   localparam logic [7:0] TSC_RESET = 8'h00;
   localparam logic [7:0] CSC_RESET = 8'h00;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [15:0] COUNT_FULL = 16'hFFFF;
   // clock source codes
   localparam logic [1:0] CLK_OFF = 2'b00;
   localparam logic [1:0] CLK_BUS = 2'b01;
   localparam logic [1:0] CLK_FIXED = 2'b10;
   localparam logic [1:0] CLK_EXTERNAL = 2'b11;
   // capture edge codes
   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_FALL = 2'b10;
   localparam logic [1:0] EDGE_BOTH = 2'b11;
   localparam logic [1:0] EDGE_NONE = 2'b00;

   typedef enum logic [1:0] {
      MODE_CAPTURE = 2'b00,
      MODE_COMPARE = 2'b01,
      MODE_EDGE_PWM = 2'b11,
      MODE_CENTER_PWM = 2'b10
   } chan_mode_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bus_req_t;
endpackage : tpm_core_pkg

// ### hdl/timer_counter_channel_value_core.sv
// 16-bit timer counter with one channel value register and byte-coherent access
// Behaviour
// - channel value holds capture or compare value; reset clears it
// - capture mode: reading one value byte freezes both until other read
// - channel control write releases the value read freeze
// - compare/pwm value writes buffered, moved after both bytes, any order
// - channel control write discards half-written value, restarts pairing
// - center select 1: counter counts up/down, channel is center pwm
// - center select 0: channel is capture, compare or edge pwm
// - after reset clock select is 0:0, counter idle
// - clock select: off, bus, fixed, external; 0:1 counts every bus clock
// - counter holds while processor halted in debug
// - stop mode halts counting; wait mode runs normally
// - up mode counts zero to terminal, wraps; terminal is modulus or all ones
// - up/down: zero to modulus and back, ends one period each
// - overflow flag readable; interrupt level while flag and enable set
// - up mode sets overflow flag on terminal to zero step
// - up/down mode sets overflow flag on modulus to next lower step
// - counter byte read captures both; no fresh value until both read
// - counter byte write clears counter and pending read capture
// - center off: two mode bits pick capture, compare or edge pwm
// - upper mode bit 1 selects edge pwm regardless of lower bit
// - capture edges: 01 rising, 10 falling, 11 both
// - edge pwm: paired value moves to active only at count zero
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module timer_counter_channel_value_core
   import tpm_core_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // register port
   input wire bus_req_t bus_req,
   output logic [7:0] rdata,
   // system state
   input wire logic debug_halt,
   input wire logic stop_mode,
   input wire logic fixed_clock_tick,
   // timer pins
   input wire logic ext_clock_in,
   input wire logic capture_in,
   // interrupt request
   output logic overflow_irq
);

   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);

   logic [7:0] timer_status_control;
   logic [7:0] channel_status_control;
   logic overflow_flag;
   logic [15:0] main_counter;
   logic count_up;
   logic [15:0] modulus;
   logic [15:0] mod_wbuf;
   logic mod_hi_w, mod_lo_w;
   logic [15:0] cnt_rbuf;
   logic cnt_latched, cnt_first_hi;
   logic [15:0] channel_value;
   logic [15:0] cv_rbuf;
   logic cv_latched, cv_first_hi;
   logic [15:0] cv_wbuf;
   logic cv_hi_w, cv_lo_w;
   logic ext_prev, cap_prev;
   logic [7:0] next_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // decode
   logic wr_tsc, wr_cnt, wr_mod_h, wr_mod_l, wr_csc, wr_cv_h, wr_cv_l;
   logic rd_cnt_h, rd_cnt_l, rd_cv_h, rd_cv_l;
   assign wr_tsc = bus_req.wr && bus_req.addr == OFS_TIMER_STATUS_CONTROL;
   assign wr_cnt = bus_req.wr && (bus_req.addr == OFS_MAIN_COUNTER_HIGH
                                  || bus_req.addr == OFS_MAIN_COUNTER_LOW);
   assign wr_mod_h = bus_req.wr && bus_req.addr == OFS_MODULUS_HIGH;
   assign wr_mod_l = bus_req.wr && bus_req.addr == OFS_MODULUS_LOW;
   assign wr_csc = bus_req.wr && bus_req.addr == OFS_CHANNEL_STATUS_CONTROL;
   assign wr_cv_h = bus_req.wr && bus_req.addr == OFS_CHANNEL_VALUE_HIGH;
   assign wr_cv_l = bus_req.wr && bus_req.addr == OFS_CHANNEL_VALUE_LOW;
   assign rd_cnt_h = bus_req.rd && bus_req.addr == OFS_MAIN_COUNTER_HIGH;
   assign rd_cnt_l = bus_req.rd && bus_req.addr == OFS_MAIN_COUNTER_LOW;
   assign rd_cv_h = bus_req.rd && bus_req.addr == OFS_CHANNEL_VALUE_HIGH;
   assign rd_cv_l = bus_req.rd && bus_req.addr == OFS_CHANNEL_VALUE_LOW;

   logic [1:0] clock_sel;
   logic center_aligned_select, overflow_interrupt_enable;
   logic [1:0] edge_sel;
   chan_mode_t chan_mode;
   assign clock_sel = timer_status_control[TSC_CLOCK_SEL_LSB +: 2];
   assign center_aligned_select = timer_status_control[TSC_CENTER_SEL_BIT];
   assign overflow_interrupt_enable = timer_status_control[TSC_OVERFLOW_IE_BIT];
   assign edge_sel = channel_status_control[CSC_EDGE_LSB +: 2];

   always_comb begin
      if (center_aligned_select) begin
         chan_mode = MODE_CENTER_PWM;
      end else if (channel_status_control[CSC_MODE_UPPER_BIT]) begin
         chan_mode = MODE_EDGE_PWM;
      end else if (channel_status_control[CSC_MODE_LOWER_BIT]) begin
         chan_mode = MODE_COMPARE;
      end else begin
         chan_mode = MODE_CAPTURE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counting clock
   logic src_tick, tick;
   always_comb begin
      unique case (clock_sel)
         CLK_OFF: src_tick = 1'b0;
         CLK_BUS: src_tick = 1'b1;
         CLK_FIXED: src_tick = fixed_clock_tick;
         CLK_EXTERNAL: src_tick = ext_clock_in && !ext_prev;
      endcase
   end
   assign tick = src_tick && !debug_halt && !stop_mode;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ext_prev <= 1'b0;
         cap_prev <= 1'b0;
      end else begin
         ext_prev <= ext_clock_in;
         cap_prev <= capture_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         timer_status_control <= TSC_RESET;
         channel_status_control <= CSC_RESET;
      end else begin
         if (wr_tsc) begin
            timer_status_control <= bus_req.wdata & TSC_WRITE_MASK;
         end
         if (wr_csc) begin
            channel_status_control <= bus_req.wdata & CSC_WRITE_MASK;
         end
      end
   end

   // modulus pairing; a status control write cancels a half pair
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         modulus <= VALUE_RESET;
         mod_wbuf <= VALUE_RESET;
         mod_hi_w <= 1'b0;
         mod_lo_w <= 1'b0;
      end else if (wr_tsc) begin
         mod_hi_w <= 1'b0;
         mod_lo_w <= 1'b0;
      end else begin
         if (wr_mod_h) begin
            mod_wbuf[15:8] <= bus_req.wdata;
         end
         if (wr_mod_l) begin
            mod_wbuf[7:0] <= bus_req.wdata;
         end
         if ((mod_hi_w || wr_mod_h) && (mod_lo_w || wr_mod_l)) begin
            modulus <= {wr_mod_h ? bus_req.wdata : mod_wbuf[15:8],
                        wr_mod_l ? bus_req.wdata : mod_wbuf[7:0]};
            mod_hi_w <= 1'b0;
            mod_lo_w <= 1'b0;
         end else begin
            mod_hi_w <= mod_hi_w || wr_mod_h;
            mod_lo_w <= mod_lo_w || wr_mod_l;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // main counter
   logic [15:0] terminal;
   logic wrap_event, turn_event;
   assign terminal = (modulus == COUNT_ZERO) ? COUNT_FULL : modulus;
   assign wrap_event = tick && !center_aligned_select && main_counter == terminal;
   assign turn_event = tick && center_aligned_select && count_up
                       && main_counter == modulus;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         main_counter <= COUNT_ZERO;
         count_up <= 1'b1;
      end else if (wr_cnt) begin
         main_counter <= COUNT_ZERO;
         count_up <= 1'b1;
      end else if (tick) begin
         if (!center_aligned_select) begin
            count_up <= 1'b1;
            main_counter <= wrap_event ? COUNT_ZERO : main_counter + COUNT_ONE;
         end else if (count_up) begin
            if (main_counter == modulus) begin
               main_counter <= main_counter - COUNT_ONE;
               count_up <= 1'b0;
            end else begin
               main_counter <= main_counter + COUNT_ONE;
            end
         end else if (main_counter == COUNT_ZERO) begin
            main_counter <= COUNT_ONE;
            count_up <= 1'b1;
         end else begin
            main_counter <= main_counter - COUNT_ONE;
         end
      end
   end

   // overflow flag: writing 0 clears, a new overflow wins
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         overflow_flag <= 1'b0;
      end else if ((wrap_event || turn_event) && !wr_cnt) begin
         overflow_flag <= 1'b1;
      end else if (wr_tsc && !bus_req.wdata[TSC_OVERFLOW_FLAG_BIT]) begin
         overflow_flag <= 1'b0;
      end
   end
   assign overflow_irq = overflow_flag && overflow_interrupt_enable;

   // counter read coherency
   always_ff @(posedge sys_clk) begin
      if (srst || wr_cnt) begin
         cnt_latched <= 1'b0;
         cnt_first_hi <= 1'b0;
         cnt_rbuf <= COUNT_ZERO;
      end else if (!cnt_latched && (rd_cnt_h || rd_cnt_l)) begin
         cnt_latched <= 1'b1;
         cnt_first_hi <= rd_cnt_h;
         cnt_rbuf <= main_counter;
      end else if (cnt_latched && ((cnt_first_hi && rd_cnt_l)
                                   || (!cnt_first_hi && rd_cnt_h))) begin
         cnt_latched <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel value
   logic cap_event, cv_pair_done, cv_move;
   logic [15:0] cv_pair;
   always_comb begin
      unique case (edge_sel)
         EDGE_RISE: cap_event = capture_in && !cap_prev;
         EDGE_FALL: cap_event = !capture_in && cap_prev;
         EDGE_BOTH: cap_event = capture_in != cap_prev;
         EDGE_NONE: cap_event = 1'b0;
      endcase
   end
   assign cv_pair_done = cv_hi_w && cv_lo_w;
   assign cv_pair = cv_wbuf;
   always_comb begin
      unique case (chan_mode)
         MODE_EDGE_PWM: cv_move = cv_pair_done && main_counter == COUNT_ZERO;
         MODE_CENTER_PWM: cv_move = cv_pair_done && turn_event;
         MODE_COMPARE: cv_move = cv_pair_done;
         MODE_CAPTURE: cv_move = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         channel_value <= VALUE_RESET;
      end else if (chan_mode == MODE_CAPTURE && cap_event) begin
         channel_value <= main_counter;
      end else if (cv_move && !wr_csc) begin
         channel_value <= cv_pair;
      end
   end

   // write pairing, either byte order
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cv_wbuf <= VALUE_RESET;
         cv_hi_w <= 1'b0;
         cv_lo_w <= 1'b0;
      end else if (wr_csc) begin
         cv_hi_w <= 1'b0;
         cv_lo_w <= 1'b0;
      end else if (chan_mode != MODE_CAPTURE) begin
         if (wr_cv_h) begin
            cv_wbuf[15:8] <= bus_req.wdata;
         end
         if (wr_cv_l) begin
            cv_wbuf[7:0] <= bus_req.wdata;
         end
         cv_hi_w <= (cv_hi_w && !cv_move) || wr_cv_h;
         cv_lo_w <= (cv_lo_w && !cv_move) || wr_cv_l;
      end
   end

   // capture read coherency
   always_ff @(posedge sys_clk) begin
      if (srst || wr_csc) begin
         cv_latched <= 1'b0;
         cv_first_hi <= 1'b0;
         cv_rbuf <= VALUE_RESET;
      end else if (chan_mode == MODE_CAPTURE && !cv_latched && (rd_cv_h || rd_cv_l)) begin
         cv_latched <= 1'b1;
         cv_first_hi <= rd_cv_h;
         cv_rbuf <= channel_value;
      end else if (cv_latched && ((cv_first_hi && rd_cv_l)
                                  || (!cv_first_hi && rd_cv_h))) begin
         cv_latched <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data
   logic [15:0] cnt_view, cv_view;
   assign cnt_view = cnt_latched ? cnt_rbuf : main_counter;
   assign cv_view = cv_latched ? cv_rbuf : channel_value;
   always_comb begin
      next_rdata = 8'h00;
      unique case (bus_req.addr)
         OFS_TIMER_STATUS_CONTROL: next_rdata = timer_status_control
                                   | {overflow_flag, 7'h00};
         OFS_MAIN_COUNTER_HIGH: next_rdata = cnt_view[15:8];
         OFS_MAIN_COUNTER_LOW: next_rdata = cnt_view[7:0];
         OFS_MODULUS_HIGH: next_rdata = modulus[15:8];
         OFS_MODULUS_LOW: next_rdata = modulus[7:0];
         OFS_CHANNEL_STATUS_CONTROL: next_rdata = channel_status_control;
         OFS_CHANNEL_VALUE_HIGH: next_rdata = cv_view[15:8];
         OFS_CHANNEL_VALUE_LOW: next_rdata = cv_view[7:0];
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= bus_req.rd ? next_rdata : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_reset_state: assert property ($past(srst) |-> clock_sel == CLK_OFF
      && channel_value == VALUE_RESET) else $error("state not cleared by reset");
   a_idle_hold: assert property ((clock_sel == CLK_OFF && !wr_cnt)
      |=> main_counter == $past(main_counter)) else $error("idle counter moved");
   a_bus_count: assert property ((clock_sel == CLK_BUS && !debug_halt
      && !stop_mode && !wr_cnt && !center_aligned_select && main_counter != terminal)
      |=> main_counter == $past(main_counter) + COUNT_ONE) else $error("no bus count");
   a_halt_hold: assert property ((debug_halt && !wr_cnt)
      |=> main_counter == $past(main_counter)) else $error("counter ran in halt");
   a_wrap_flag: assert property ((wrap_event && !wr_cnt)
      |=> main_counter == COUNT_ZERO && overflow_flag) else $error("wrap wrong");
   a_turn_flag: assert property ((turn_event && !wr_cnt)
      |=> overflow_flag && !count_up) else $error("turnaround wrong");
   a_irq_level: assert property (((wrap_event || turn_event) && !wr_cnt && !wr_tsc
      && overflow_interrupt_enable) |=> overflow_irq) else $error("irq missing");
   a_counter_clear: assert property (wr_cnt
      |=> main_counter == COUNT_ZERO && !cnt_latched) else $error("no clear");
   a_read_frozen: assert property ((cnt_latched && !wr_cnt)
      |=> cnt_rbuf == $past(cnt_rbuf)) else $error("counter capture moved");
   a_csc_release: assert property (wr_csc
      |=> !cv_latched && !cv_hi_w && !cv_lo_w) else $error("csc write ignored");
   a_epwm_zero: assert property ((chan_mode == MODE_EDGE_PWM && cv_pair_done
      && main_counter != COUNT_ZERO && !wr_csc) |=> !$changed(channel_value))
      else $error("pwm value moved off zero");

   c_wrap: cover property (wrap_event);
   c_turn: cover property (turn_event ##[1:40] main_counter == COUNT_ZERO);
   c_capture: cover property (chan_mode == MODE_CAPTURE && cap_event);
   c_pwm_load: cover property (chan_mode == MODE_EDGE_PWM && cv_move);

endmodule : timer_counter_channel_value_core

// ### verif/timer_pin_model.sv
// timer pin model: external count clock, fixed clock tick and capture pin
`timescale 1ns/1ps
module timer_pin_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // timer pins
   output logic ext_clock_in,
   output logic fixed_clock_tick,
   output logic capture_in
);
   logic [2:0] phase;

   initial begin
      phase = 3'h0;
      ext_clock_in = 1'b0;
      fixed_clock_tick = 1'b0;
      capture_in = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // free running pins, external clock at a quarter of sys_clk
   always @(posedge sys_clk) begin
      phase <= srst ? 3'h0 : phase + 3'h1;
      ext_clock_in <= phase[1];
      fixed_clock_tick <= (phase == 3'h7);
   end

   task automatic set_capture(input logic level);
      @(posedge sys_clk);
      capture_in <= level;
   endtask : set_capture
endmodule : timer_pin_model

// ### verif/test_timer_counter_channel_value_core.sv
// self-checking bench for the timer counter and channel value core
`timescale 1ns/1ps
module test_timer_counter_channel_value_core
   import tpm_core_pkg::*;
;
   logic sys_clk;
   logic srst;
   bus_req_t bus_req;
   logic [7:0] rdata;
   logic debug_halt;
   logic stop_mode;
   logic fixed_clock_tick;
   logic ext_clock_in;
   logic capture_in;
   logic overflow_irq;
   int fails;
   int samples_checked;
   int cycles;
   logic [7:0] d;
   logic [15:0] v;
   logic [15:0] exp_val;
   logic [15:0] c;

   timer_counter_channel_value_core i_timer_counter_channel_value_core (
      .sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .rdata(rdata),
      .debug_halt(debug_halt), .stop_mode(stop_mode), .fixed_clock_tick(fixed_clock_tick),
      .ext_clock_in(ext_clock_in), .capture_in(capture_in), .overflow_irq(overflow_irq)
   );
   timer_pin_model i_timer_pin_model (
      .sys_clk(sys_clk), .srst(srst), .ext_clock_in(ext_clock_in),
      .fixed_clock_tick(fixed_clock_tick), .capture_in(capture_in)
   );

   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         fails = fails + 1;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] expected);
      samples_checked = samples_checked + 1;
      if (seen !== expected) begin
         fails = fails + 1;
         $display("unexpected at %0t ns: read %h, wanted %h", $time, seen, expected);
      end
   endtask : check

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      bus_req.wr <= 1'b1;
      bus_req.addr <= addr;
      bus_req.wdata <= data;
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge sys_clk);
      bus_req.rd <= 1'b1;
      bus_req.addr <= addr;
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1;
      data = rdata;
   endtask : rd

   task automatic rd16(input logic [7:0] addr, output logic [15:0] val);
      logic [7:0] hi;
      logic [7:0] lo;
      rd(addr, hi);
      rd(8'(addr + 8'h01), lo);
      val = {hi, lo};
   endtask : rd16

   task automatic wr16(input logic [7:0] addr, input logic [15:0] val);
      wr(addr, val[15:8]);
      wr(8'(addr + 8'h01), val[7:0]);
   endtask : wr16

   // exactly n counting edges between two halts
   task automatic run(input int n);
      @(posedge sys_clk);
      debug_halt <= 1'b0;
      repeat (n) @(posedge sys_clk);
      debug_halt <= 1'b1;
   endtask : run

   task automatic cap(input logic level);
      i_timer_pin_model.set_capture(level);
      repeat (3) @(posedge sys_clk);
   endtask : cap

   task automatic summarize();
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      fails = 0;
      samples_checked = 0;
      cycles = 0;
      srst = 1'b1;
      bus_req = '0;
      debug_halt = 1'b1;
      stop_mode = 1'b0;
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      rd(OFS_TIMER_STATUS_CONTROL, d);
      check({8'h00, d}, 16'h0000);
      rd16(OFS_CHANNEL_VALUE_HIGH, v);
      check(v, 16'h0000);
      wr(8'h08, 8'hFF);
      rd(8'h08, d);
      check({8'h00, d}, 16'h0000);
      run(20);
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0000);
      $display("test reset_state done");
      wr16(OFS_MODULUS_HIGH, 16'h0009);
      wr(OFS_TIMER_STATUS_CONTROL, 8'h48);
      wr(OFS_MAIN_COUNTER_LOW, 8'hA5);
      run(9);
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0009);
      rd(OFS_TIMER_STATUS_CONTROL, d);
      check({8'h00, d}, 16'h0048);
      check({15'h0000, overflow_irq}, 16'h0000);
      run(1);
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0000);
      rd(OFS_TIMER_STATUS_CONTROL, d);
      check({8'h00, d}, 16'h00C8);
      check({15'h0000, overflow_irq}, 16'h0001);
      wr(OFS_TIMER_STATUS_CONTROL, 8'h88);
      #1;
      check({15'h0000, overflow_irq}, 16'h0000);
      wr(OFS_TIMER_STATUS_CONTROL, 8'h08);
      rd(OFS_TIMER_STATUS_CONTROL, d);
      check({8'h00, d}, 16'h0008);
      $display("test up_count done");
      fork
         run(53);
         begin
            rd(OFS_MAIN_COUNTER_HIGH, d);
            repeat (20) @(posedge sys_clk);
            rd(OFS_MAIN_COUNTER_LOW, v[7:0]);
         end
      join
      check({d, v[7:0]}, 16'h0000);
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0003);
      rd(OFS_MAIN_COUNTER_HIGH, d);
      wr(OFS_MAIN_COUNTER_HIGH, 8'h5A);
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0000);
      $display("test counter_coherence done");
      wr(OFS_TIMER_STATUS_CONTROL, 8'h28);
      run(9);
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0009);
      rd(OFS_TIMER_STATUS_CONTROL, d);
      check({8'h00, d}, 16'h0028);
      run(1);
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0008);
      rd(OFS_TIMER_STATUS_CONTROL, d);
      check({8'h00, d}, 16'h00A8);
      run(8);
      run(1);
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0001);
      @(posedge sys_clk);
      stop_mode <= 1'b1;
      run(10);
      @(posedge sys_clk);
      stop_mode <= 1'b0;
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0001);
      repeat (10) @(posedge sys_clk);
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0001);
      $display("test up_down_count done");
      wr(OFS_TIMER_STATUS_CONTROL, 8'h10);
      wr16(OFS_MODULUS_HIGH, 16'h0000);
      wr(OFS_MAIN_COUNTER_LOW, 8'h00);
      run(40);
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0005);
      wr(OFS_TIMER_STATUS_CONTROL, 8'h18);
      wr(OFS_MAIN_COUNTER_LOW, 8'h00);
      run(40);
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h000A);
      $display("test clock_sources done");
      wr(OFS_TIMER_STATUS_CONTROL, 8'h08);
      wr16(OFS_MODULUS_HIGH, 16'h0009);
      wr(OFS_MAIN_COUNTER_LOW, 8'h00);
      c = 16'h0000;
      exp_val = 16'h0000;
      for (int e = 1; e < 4; e++) begin
         wr(OFS_CHANNEL_STATUS_CONTROL, 8'(e << 2));
         run(3);
         c = (c + 16'h0003) % 16'h000A;
         cap(1'b1);
         if (e[0]) exp_val = c;
         rd16(OFS_CHANNEL_VALUE_HIGH, v);
         check(v, exp_val);
         run(3);
         c = (c + 16'h0003) % 16'h000A;
         cap(1'b0);
         if (e[1]) exp_val = c;
         rd16(OFS_CHANNEL_VALUE_HIGH, v);
         check(v, exp_val);
      end
      rd(OFS_CHANNEL_VALUE_HIGH, d);
      run(3);
      c = (c + 16'h0003) % 16'h000A;
      cap(1'b1);
      rd(OFS_CHANNEL_VALUE_LOW, v[7:0]);
      check({d, v[7:0]}, exp_val);
      rd16(OFS_CHANNEL_VALUE_HIGH, v);
      check(v, c);
      rd(OFS_CHANNEL_VALUE_HIGH, d);
      run(3);
      c = (c + 16'h0003) % 16'h000A;
      cap(1'b0);
      wr(OFS_CHANNEL_STATUS_CONTROL, 8'h0C);
      rd(OFS_CHANNEL_VALUE_LOW, d);
      check({8'h00, d}, {8'h00, c[7:0]});
      $display("test capture done");
      wr(OFS_CHANNEL_STATUS_CONTROL, 8'h10);
      wr(OFS_CHANNEL_VALUE_LOW, 8'h34);
      rd16(OFS_CHANNEL_VALUE_HIGH, v);
      check(v, c);
      wr(OFS_CHANNEL_VALUE_HIGH, 8'h12);
      rd16(OFS_CHANNEL_VALUE_HIGH, v);
      check(v, 16'h1234);
      wr(OFS_CHANNEL_VALUE_HIGH, 8'h56);
      wr(OFS_CHANNEL_STATUS_CONTROL, 8'h10);
      wr(OFS_CHANNEL_VALUE_LOW, 8'h9A);
      rd16(OFS_CHANNEL_VALUE_HIGH, v);
      check(v, 16'h1234);
      wr(OFS_CHANNEL_VALUE_HIGH, 8'h78);
      rd16(OFS_CHANNEL_VALUE_HIGH, v);
      check(v, 16'h789A);
      $display("test compare_pairing done");
      wr(OFS_CHANNEL_STATUS_CONTROL, 8'h38);
      if (c == 16'h0000) begin
         run(1);
         c = 16'h0001;
      end
      wr16(OFS_CHANNEL_VALUE_HIGH, 16'hABCD);
      rd16(OFS_CHANNEL_VALUE_HIGH, v);
      check(v, 16'h789A);
      run(int'(16'h000A - c));
      rd16(OFS_MAIN_COUNTER_HIGH, v);
      check(v, 16'h0000);
      rd16(OFS_CHANNEL_VALUE_HIGH, v);
      check(v, 16'hABCD);
      $display("test edge_pwm done");
      wr(OFS_TIMER_STATUS_CONTROL, 8'h28);
      wr16(OFS_CHANNEL_VALUE_HIGH, 16'h0005);
      run(9);
      rd16(OFS_CHANNEL_VALUE_HIGH, v);
      check(v, 16'hABCD);
      run(1);
      rd16(OFS_CHANNEL_VALUE_HIGH, v);
      check(v, 16'h0005);
      $display("test center_pwm done");
      summarize();
   end
endmodule : test_timer_counter_channel_value_core
